// >>> logic/dbcs_defs.vh
// timing constants and code values for the diagnostic blink sequencer
`ifndef DBCS_DEFS_VH
`define DBCS_DEFS_VH
`define DBCS_CLK_HZ        25000000
`define DBCS_LONG_MS       2000
`define DBCS_FAST_MS       100
`define DBCS_SLOW_MS       400
`define DBCS_GAP_MS        1000
`define DBCS_REPEAT_MS     3000
`define DBCS_MS_CYC(ms)    ((ms) * (`DBCS_CLK_HZ / 1000))
`define DBCS_FAST_COUNT    10
`define DBCS_RING_EEPROM   8'h01
`define DBCS_RING_RSVD     8'h02
`define DBCS_RING_BREAK    8'h03
`define DBCS_RING_TELEG    8'h04
`define DBCS_RING_REGACC   8'h05
`define DBCS_RING_CPLX     8'h0B
`define DBCS_RING_MANY     8'h0C
`endif

// >>> logic/dbcs_sequencer.v
// diagnostic indicator sequencer: run, power and fault blink codes
`timescale 1ns/1ps
`include "dbcs_defs.vh"

// Function
// RULE1: ring bus fault report starts with one long flash of about two seconds.
// RULE2: terminal bus fault is announced by a burst of fast blinks.
// RULE3: terminal report is fast marker, slow code pulses, slow argument pulses.
// RULE4: fault indicator uses a fast rate and a slow rate.
// RULE5: with both buses faulty, terminal fault is shown before ring fault.
// RULE6: every code is preceded by its own bus's introductory signal.
// RULE7: after start-up check, error-free start leaves fault indicator dark.
// RULE8: run indicator lit only when fault-free and fieldbus runs.
// RULE9: power indicator lit when supply is correct.
// RULE10: ring code 1 arg 0 is config memory checksum; code 2 never emitted.
// RULE11: ring code 3 break; argument n,m gives position n*10+m.
// RULE12: ring code 4 arg n for more than a quarter faulty telegrams.
// RULE13: ring code 5 arg n for failed register access to module n.
// RULE14: ring code 11 arg n for complex module n working incorrectly.
// RULE15: ring code 12 when the ring holds more than 120 modules.
// RULE16: fault indicator off in normal exchange or without cyclic data.
// RULE17: terminal argument is the last active terminal position before fault.
// RULE18: latched faults keep blinking until power cycle; code holds only faults flagged sticky, until reset.
// RULE19: blink periods, gaps and repeat interval are clock-derived parameters.
module dbcs_sequencer
#(
  // RULE19 clock-derived timing
  parameter LONG_CYC   = `DBCS_MS_CYC(`DBCS_LONG_MS),
  parameter FAST_CYC   = `DBCS_MS_CYC(`DBCS_FAST_MS),
  parameter SLOW_CYC   = `DBCS_MS_CYC(`DBCS_SLOW_MS),
  parameter GAP_CYC    = `DBCS_MS_CYC(`DBCS_GAP_MS),
  parameter REPEAT_CYC = `DBCS_MS_CYC(`DBCS_REPEAT_MS)
)
(
  // clock and reset
  input  wire       ref_clk,
  input  wire       rst_b,
  // start-up and supply status
  input  wire       cfgCheckDone,
  input  wire       supplyOk,
  input  wire       fieldbusRun,
  // terminal bus fault
  input  wire       termFault,
  input  wire       termSticky,
  input  wire [7:0] termCode,
  input  wire [7:0] termArg,
  // ring bus fault
  input  wire       ringFault,
  input  wire       ringSticky,
  input  wire [7:0] ringCode,
  input  wire [3:0] ringArgN,
  input  wire [3:0] ringArgM,
  input  wire       ringArgValid,
  // indicators
  output reg        runLed,
  output reg        powerLed,
  output reg        faultLed
);

////////////////////////////////////////////////////////////////////////////////
localparam S_IDLE  = 3'd0;
localparam S_INTRO = 3'd1;
localparam S_GAP1  = 3'd2;
localparam S_CODE  = 3'd3;
localparam S_GAP2  = 3'd4;
localparam S_ARG   = 3'd5;
localparam S_REST  = 3'd6;

// synchronisers for every pin-level input
// codes are read only while their fault level is steady, so per-bit syncs suffice
reg [1:0]  sDone, sSup, sRun, sTf, sTs, sRf, sRs, sRv;
reg [7:0]  tc1, tc2, ta1, ta2, rc1, rc2;
reg [3:0]  rn1, rn2, rm1, rm2;

always @(posedge ref_clk or negedge rst_b)
begin
  if (!rst_b)
  begin
    sDone <= 2'h0; sSup <= 2'h0; sRun <= 2'h0; sTf <= 2'h0;
    sTs <= 2'h0; sRf <= 2'h0; sRs <= 2'h0; sRv <= 2'h0;
    tc1 <= 8'h00; tc2 <= 8'h00; ta1 <= 8'h00; ta2 <= 8'h00;
    rc1 <= 8'h00; rc2 <= 8'h00;
    rn1 <= 4'h0; rn2 <= 4'h0; rm1 <= 4'h0; rm2 <= 4'h0;
  end
  else
  begin
    sDone <= {sDone[0], cfgCheckDone};
    sSup  <= {sSup[0], supplyOk};
    sRun  <= {sRun[0], fieldbusRun};
    sTf   <= {sTf[0], termFault};
    sTs   <= {sTs[0], termSticky};
    sRf   <= {sRf[0], ringFault};
    sRs   <= {sRs[0], ringSticky};
    sRv   <= {sRv[0], ringArgValid};
    tc1 <= termCode; tc2 <= tc1;
    ta1 <= termArg;  ta2 <= ta1;
    rc1 <= ringCode; rc2 <= rc1;
    rn1 <= ringArgN; rn2 <= rn1;
    rm1 <= ringArgM; rm2 <= rm1;
  end
end

////////////////////////////////////////////////////////////////////////////////
// latched fault captures
reg        tLat, tStk, rLat, rStk;
reg [7:0]  tCodeL, tArgL, rCodeL, rArgL;
reg        rArgOn;
// ring code 2 is reserved and never captured
// a zero code from a quiet ring is no fault either
wire       ringLegal = (rc2 != `DBCS_RING_RSVD) && (rc2 != 8'h00);
// ring break location folds n and m into one position
wire [7:0] ringArgFold = (rc2 == `DBCS_RING_BREAK) ?
                         (({4'h0, rn2} << 3) + ({4'h0, rn2} << 1) + {4'h0, rm2}) :
                         {4'h0, rn2};

always @(posedge ref_clk or negedge rst_b)
begin
  if (!rst_b)
  begin
    tLat <= 1'b0; tStk <= 1'b0; rLat <= 1'b0; rStk <= 1'b0;
    tCodeL <= 8'h00; tArgL <= 8'h00; rCodeL <= 8'h00; rArgL <= 8'h00;
    rArgOn <= 1'b0;
  end
  else
  begin
    // limitation: a new code while the fault stays high replaces the held one
    // RULE17 argument counts active terminals only
    if (sTf[1])
    begin
      tLat <= 1'b1;
      tStk <= tStk | sTs[1];
      tCodeL <= tc2;
      tArgL <= ta2;
    end
    // sticky bits clear only on reset, standing in for a power cycle
    // RULE18 sticky faults survive their cause
    else if (!tStk)
      tLat <= 1'b0;
    // RULE10 code 2 reserved, code 1 arg 0
    if (sRf[1] && ringLegal)
    begin
      rLat <= 1'b1;
      rStk <= rStk | sRs[1];
      rCodeL <= rc2;
      // RULE11 RULE12 RULE13 RULE14 RULE15 argument forms per code
      rArgOn <= sRv[1] && (rc2 != `DBCS_RING_MANY);
      rArgL <= (rc2 == `DBCS_RING_EEPROM) ? 8'h00 : ringArgFold;
    end
    else if (!rStk)
      rLat <= 1'b0;
  end
end

////////////////////////////////////////////////////////////////////////////////
// report sequencer
reg [2:0]  state;
reg        curRing;
reg [31:0] timer;
reg [7:0]  pulses;
reg        phase;
reg        ledNext;

// fast burst phases: one on and one off per pulse, ending on an off phase
localparam [31:0] BURST_PHASES = `DBCS_FAST_COUNT * 2 - 1;
// timer loads N-1 so a phase lasts N cycles; state steps add one cycle
wire        tDone   = (timer == 32'h0);

always @(posedge ref_clk or negedge rst_b)
begin
  if (!rst_b)
  begin
    state <= S_IDLE; curRing <= 1'b0; timer <= 32'h0;
    pulses <= 8'h00; phase <= 1'b0; ledNext <= 1'b0;
  end
  else if (!tDone)
    timer <= timer - 32'h1;
  else
  begin
    case (state)
      S_IDLE:
      begin
        // idle also waits out the repeat pause before reading the latches
        ledNext <= 1'b0;
        // RULE7 nothing shown before the start-up check
        if (sDone[1] && (tLat || rLat))
        begin
          // RULE5 terminal fault first
          curRing <= !tLat;
          state <= S_INTRO;
          phase <= 1'b1;
          ledNext <= 1'b1;
          // RULE6 RULE1 long flash for ring, fast burst for terminal
          timer <= tLat ? FAST_CYC - 1 : LONG_CYC - 1;
          pulses <= BURST_PHASES[7:0];
        end
      end
      S_INTRO:
      begin
        // RULE2 RULE4 fast burst toggles at the fast rate
        if (!curRing && pulses != 8'h00)
        begin
          phase <= ~phase;
          ledNext <= ~phase;
          pulses <= pulses - 8'h1;
          timer <= FAST_CYC - 1;
        end
        else
        begin
          ledNext <= 1'b0;
          state <= S_GAP1;
          timer <= GAP_CYC - 1;
        end
      end
      S_GAP1:
      begin
        // RULE3 code pulses at the slow rate
        state <= S_CODE;
        pulses <= curRing ? rCodeL : tCodeL;
        phase <= 1'b0;
        timer <= 32'h0;
      end
      S_CODE, S_ARG:
      begin
        // code zero gives no pulses, only the gaps around it
        // RULE4 slow pulses, one on and one off per count
        if (phase)
        begin
          phase <= 1'b0;
          ledNext <= 1'b0;
          timer <= SLOW_CYC - 1;
        end
        else if (pulses != 8'h00)
        begin
          phase <= 1'b1;
          ledNext <= 1'b1;
          pulses <= pulses - 8'h1;
          timer <= SLOW_CYC - 1;
        end
        else if (state == S_CODE)
        begin
          state <= S_GAP2;
          timer <= GAP_CYC - 1;
        end
        else
        begin
          state <= S_REST;
          timer <= GAP_CYC - 1;
        end
      end
      S_GAP2:
      begin
        // RULE3 argument sequence follows the code
        state <= S_ARG;
        pulses <= curRing ? (rArgOn ? rArgL : 8'h00) : tArgL;
        phase <= 1'b0;
      end
      S_REST:
      begin
        // RULE5 ring fault second, then repeat after rest
        // a cause cleared mid-report still lets the report in flight finish
        if (!curRing && rLat)
        begin
          curRing <= 1'b1;
          state <= S_INTRO;
          ledNext <= 1'b1;
          timer <= LONG_CYC - 1;
        end
        else
        begin
          state <= S_IDLE;
          timer <= REPEAT_CYC - 1;
        end
      end
      default:
        state <= S_IDLE;
    endcase
  end
end

////////////////////////////////////////////////////////////////////////////////
// indicator outputs, all registered
// registered so the pins never glitch on state decode
always @(posedge ref_clk or negedge rst_b)
begin
  if (!rst_b)
  begin
    runLed <= 1'b0;
    powerLed <= 1'b0;
    faultLed <= 1'b0;
  end
  else
  begin
    // run waits for the start-up check like the fault report
    // RULE8 run only when fault-free with fieldbus running
    runLed <= sDone[1] && sRun[1] && !tLat && !rLat;
    // RULE9 supply correct
    powerLed <= sSup[1];
    // RULE16 dark whenever no report is in progress
    faultLed <= ledNext && (state != S_IDLE || tLat || rLat);
  end
end

endmodule // dbcs_sequencer

// >>> verif/dbcs_checker.sv
// concurrent checks on the indicator outputs
`timescale 1ns/1ps
module dbcs_checker
#(
  parameter LONG_CYC = 16,
  parameter FAST_CYC = 2,
  parameter SLOW_CYC = 6
)
(
  // clock and reset
  input wire       ref_clk,
  input wire       rst_b,
  // status and faults
  input wire       cfgCheckDone,
  input wire       supplyOk,
  input wire       fieldbusRun,
  input wire       termFault,
  input wire       ringFault,
  input wire [7:0] ringCode,
  // indicators
  input wire       runLed,
  input wire       powerLed,
  input wire       faultLed
);
  reg [7:0] onLen;
  reg       seen;
  // seen stays set: a latched fault may outlive its input
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      onLen <= 8'h00;
      seen <= 1'b0;
    end
    else
    begin
      onLen <= faultLed ? onLen + 8'h01 : 8'h00;
      if (termFault || (ringFault && ringCode != 8'h02 && ringCode != 8'h00))
        seen <= 1'b1;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence sSupplyUp; supplyOk[*6]; endsequence
  sequence sSupplyDown; !supplyOk[*6]; endsequence
  sequence sBlinkEnd; faultLed ##1 !faultLed; endsequence
  a_power_lit: assert property (sSupplyUp |-> powerLed)
    else $error("power dark");
  a_power_dark: assert property (sSupplyDown |-> !powerLed)
    else $error("power lit");
  a_run_no_done: assert property (!cfgCheckDone[*6] |-> !runLed)
    else $error("run lit early");
  a_run_no_bus: assert property (!fieldbusRun[*6] |-> !runLed)
    else $error("run lit no bus");
  a_run_fault: assert property (termFault[*6] |-> !runLed)
    else $error("run lit on fault");
  a_run_lit: assert property ((cfgCheckDone && fieldbusRun && !seen)[*6] |-> runLed)
    else $error("run dark");
  a_quiet_dark: assert property (!seen[*2] |-> !faultLed)
    else $error("fault lit no fault");
  a_blink_width: assert property (sBlinkEnd |-> onLen inside
    {[FAST_CYC-1:FAST_CYC+1], [SLOW_CYC-1:SLOW_CYC+2], [LONG_CYC-1:LONG_CYC+2]})
    else $error("odd blink width");
endmodule // dbcs_checker

// >>> verif/dbcs_led_observer.sv
// operator model: turns fault indicator into pulse symbols
`timescale 1ns/1ps
module dbcs_led_observer
#(
  parameter FAST_CYC = 2,
  parameter SLOW_CYC = 6,
  parameter GAP_CYC  = 10
)
(
  // clock and indicator
  input wire ref_clk,
  input wire faultLed
);
  // 0 gap, 1 fast, 2 slow, 3 long
  int syms[$];
  int onCnt = 0;
  int offCnt = 0;
  always @(posedge ref_clk)
  begin
    if (faultLed)
    begin
      if (offCnt >= GAP_CYC - 1 && syms.size() > 0)
        syms.push_back(0);
      offCnt <= 0;
      onCnt <= onCnt + 1;
    end
    else
    begin
      if (onCnt > 0)
        syms.push_back(onCnt <= FAST_CYC + 1 ? 1 : onCnt <= SLOW_CYC + 2 ? 2 : 3);
      onCnt <= 0;
      offCnt <= offCnt + 1;
    end
  end
endmodule // dbcs_led_observer

// >>> verif/diag_blink_code_sequencer_tb.sv
// self-checking bench for the blink sequencer
`timescale 1ns/1ps
`include "dbcs_defs.vh"
module diag_blink_code_sequencer_tb;
  logic       ref_clk = 1'b0;
  logic       rst_b = 1'b0;
  logic       cfgCheckDone = 1'b0;
  logic       supplyOk = 1'b1;
  logic       fieldbusRun = 1'b1;
  logic       termFault = 1'b0;
  logic       termSticky = 1'b0;
  logic [7:0] termCode = 8'h00;
  logic [7:0] termArg = 8'h00;
  logic       ringFault = 1'b0;
  logic       ringSticky = 1'b0;
  logic [7:0] ringCode = 8'h00;
  logic [3:0] ringArgN = 4'h0;
  logic [3:0] ringArgM = 4'h0;
  logic       ringArgValid = 1'b0;
  wire        runLed;
  wire        powerLed;
  wire        faultLed;
  int         err_count = 0;
  int         samples_checked = 0;
  int         exp[$];
  always #20 ref_clk = ~ref_clk;
  dbcs_sequencer #(.LONG_CYC(16), .FAST_CYC(2), .SLOW_CYC(6), .GAP_CYC(10), .REPEAT_CYC(12)) DUT
    (.ref_clk(ref_clk), .rst_b(rst_b), .cfgCheckDone(cfgCheckDone), .supplyOk(supplyOk),
     .fieldbusRun(fieldbusRun), .termFault(termFault), .termSticky(termSticky),
     .termCode(termCode), .termArg(termArg), .ringFault(ringFault), .ringSticky(ringSticky),
     .ringCode(ringCode), .ringArgN(ringArgN), .ringArgM(ringArgM),
     .ringArgValid(ringArgValid), .runLed(runLed), .powerLed(powerLed), .faultLed(faultLed));
  // observer defaults match the pulse widths set on DUT
  dbcs_led_observer obs
    (.ref_clk(ref_clk), .faultLed(faultLed));
  task tick(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask
  task chk_bit(input string nm, input logic got, input logic want);
    samples_checked++;
    if (got !== want)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %b seen %b", nm, want, got);
    end
  endtask
  task chk_seq(input string nm);
    int got;
    samples_checked++;
    // empty report: nothing may blink
    if (exp.size() == 0)
      exp.push_back(-1);
    foreach (exp[i])
    begin
      got = (i < obs.syms.size()) ? obs.syms[i] : -1;
      if (got != exp[i])
      begin
        err_count++;
        $display("CHECK FAILED %s[%0d] expected %0d seen %0d", nm, i, exp[i], got);
        break;
      end
    end
  endtask
  function automatic void report(int ring, int code, int arg);
    repeat (ring ? 1 : `DBCS_FAST_COUNT) exp.push_back(ring ? 3 : 1);
    exp.push_back(0);
    repeat (code) exp.push_back(2);
    exp.push_back(0);
    repeat (arg) exp.push_back(2);
    if (arg > 0)
      exp.push_back(0);
  endfunction
  task restart;
    rst_b = 1'b0;
    termFault = 1'b0;
    termSticky = 1'b0;
    ringFault = 1'b0;
    ringSticky = 1'b0;
    cfgCheckDone = 1'b0;
    tick(16);
    rst_b = 1'b1;
    tick(8);
    chk_bit("runLed", runLed, 1'b0);
    cfgCheckDone = 1'b1;
    exp.delete();
    obs.syms.delete();
  endtask
  task t_idle;
    restart();
    tick(8);
    chk_bit("runLed", runLed, 1'b1);
    chk_bit("powerLed", powerLed, 1'b1);
    chk_bit("faultLed", faultLed, 1'b0);
    supplyOk = 1'b0;
    fieldbusRun = 1'b0;
    tick(8);
    chk_bit("powerLed", powerLed, 1'b0);
    chk_bit("runLed", runLed, 1'b0);
    supplyOk = 1'b1;
    fieldbusRun = 1'b1;
    // a fault before the start-up check must stay dark
    cfgCheckDone = 1'b0;
    termFault = 1'b1;
    tick(12);
    chk_bit("faultLed", faultLed, 1'b0);
    termFault = 1'b0;
  endtask
  // sticky fault is dropped early and must keep blinking
  task t_ring(input logic [7:0] c, input logic [3:0] n, input logic [3:0] m, input logic v,
              input int arg, input logic sticky);
    restart();
    ringCode = c;
    ringArgN = n;
    ringArgM = m;
    ringArgValid = v;
    ringSticky = sticky;
    ringFault = 1'b1;
    if (c != `DBCS_RING_RSVD)
      report(1, int'(c), arg);
    tick(20);
    chk_bit("runLed", runLed, c == `DBCS_RING_RSVD);
    ringFault = !sticky;
    tick(400);
    chk_seq("ring");
    chk_bit("runLed", runLed, c == `DBCS_RING_RSVD);
  endtask
  task t_term(input logic [7:0] c, input logic [7:0] arg, input logic ring,
              input logic sticky);
    restart();
    termCode = c;
    termArg = arg;
    termSticky = sticky;
    termFault = 1'b1;
    ringCode = `DBCS_RING_REGACC;
    ringArgN = 4'h2;
    ringArgValid = 1'b1;
    ringFault = ring;
    report(0, int'(c), int'(arg));
    if (ring)
      report(1, 5, 2);
    tick(20);
    termFault = !sticky;
    tick(400);
    chk_seq("term");
    chk_bit("runLed", runLed, 1'b0);
  endtask
  task close_out;
    if (err_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    t_idle();
    t_ring(`DBCS_RING_EEPROM, 4'h5, 4'h0, 1'b1, 0, 1'b0);
    t_ring(`DBCS_RING_RSVD, 4'h1, 4'h0, 1'b1, 0, 1'b0);
    t_ring(`DBCS_RING_BREAK, 4'h1, 4'h2, 1'b1, 12, 1'b0);
    t_ring(`DBCS_RING_BREAK, 4'h1, 4'h2, 1'b0, 0, 1'b0);
    t_ring(`DBCS_RING_TELEG, 4'h2, 4'h0, 1'b1, 2, 1'b0);
    t_ring(`DBCS_RING_REGACC, 4'h1, 4'h0, 1'b1, 1, 1'b0);
    t_ring(`DBCS_RING_CPLX, 4'h3, 4'h0, 1'b1, 3, 1'b0);
    t_ring(`DBCS_RING_MANY, 4'h4, 4'h0, 1'b1, 0, 1'b0);
    t_ring(`DBCS_RING_EEPROM, 4'h0, 4'h0, 1'b0, 0, 1'b1);
    t_term(8'h02, 8'h03, 1'b0, 1'b0);
    t_term(8'h01, 8'h03, 1'b1, 1'b0);
    t_term(8'h04, 8'h02, 1'b0, 1'b1);
    close_out();
  end
endmodule // diag_blink_code_sequencer_tb
bind dbcs_sequencer dbcs_checker #(.LONG_CYC(LONG_CYC), .FAST_CYC(FAST_CYC), .SLOW_CYC(SLOW_CYC))
  chk (.ref_clk(ref_clk), .rst_b(rst_b), .cfgCheckDone(cfgCheckDone), .supplyOk(supplyOk),
       .fieldbusRun(fieldbusRun), .termFault(termFault), .ringFault(ringFault),
       .ringCode(ringCode), .runLed(runLed), .powerLed(powerLed), .faultLed(faultLed));
